/* File: rtl/uic_pkg.sv */
// Shared constants and types for the serial channel register block.
package uic_pkg;
   // Register addresses on the three-bit host bus.
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_MASK = 3'h1;
   localparam logic [2:0] A_CTRL = 3'h2;
   localparam logic [2:0] A_LINE_CTL = 3'h3;
   localparam logic [2:0] A_RES1 = 3'h4;
   localparam logic [2:0] A_RES2 = 3'h5;
   localparam logic [2:0] A_PAU1 = 3'h6;
   localparam logic [2:0] A_PAU2 = 3'h7;
   localparam logic [2:0] A_LINE_STAT = 3'h5;
   // Field positions and special values.
   localparam logic [7:0] LINE_CTL_ENHANCED = 8'hbf;
   localparam int LINE_CTL_DIV_BIT = 7;
   localparam int ENH_ENABLE_BIT = 4;
   localparam int FIFO_CTL_EN_BIT = 0;
   localparam int FIFO_CTL_RXRST_BIT = 1;
   localparam int M_RX = 0;
   localparam int M_TX = 1;
   localparam int M_LS = 2;
   localparam int M_MS = 3;
   localparam int M_STOP = 5;
   localparam int M_RTS = 6;
   localparam int M_CTS = 7;
   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [1:0] RST_TRIG = 2'h0;
   // Interrupt source codes, bits 5 to 0.
   localparam logic [5:0] SRC_NONE = 6'h01;
   localparam logic [5:0] SRC_LS = 6'h06;
   localparam logic [5:0] SRC_RX = 6'h04;
   localparam logic [5:0] SRC_TX = 6'h02;
   localparam logic [5:0] SRC_MS = 6'h00;
   localparam logic [5:0] SRC_STOP = 6'h10;
   localparam logic [5:0] SRC_FLOW = 6'h20;
   // Receive trigger levels for a 16-deep buffer.
   localparam logic [4:0] RX_TRIG_0 = 5'h01;
   localparam logic [4:0] RX_TRIG_1 = 5'h04;
   localparam logic [4:0] RX_TRIG_2 = 5'h08;
   localparam logic [4:0] RX_TRIG_3 = 5'h0e;
   // One received character with its error flags.
   typedef struct packed {
      logic [7:0] data;
      logic brk;
      logic frame;
      logic parity;
   } uic_char_t;
   // Configuration handed to the baud, transmit and flow logic.
   typedef struct packed {
      logic [7:0] div_low;
      logic [7:0] div_high;
      logic [7:0] fraction;
      logic [7:0] enhanced;
      logic [7:0] resume1;
      logic [7:0] resume2;
      logic [7:0] pause1;
      logic [7:0] pause2;
      logic [7:0] line_ctl;
      logic [7:0] mask;
      logic fifo_en;
      logic [1:0] tx_trig;
   } uic_cfg_t;
endpackage

/* File: rtl/uic_regs.sv */
// Channel register block: divisors, enhanced map, interrupt mask, line status.
`timescale 1ns/1ps


// ****************************************
// Receive buffer
// ****************************************
module uic_fifo #(
   parameter int WIDTH = 11,
   parameter int DEPTH = 16,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic clock, // System clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic flush, // Empties the buffer.
   input wire logic in_valid, // Write data offered.
   input wire logic [WIDTH-1:0] in_data, // Write data.
   output logic in_ready, // Space available.
   output logic out_valid, // Head data present.
   output logic [WIDTH-1:0] out_data, // Head data.
   input wire logic out_ready, // Head taken.
   output logic [CW-1:0] count // Words held.
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic push;
   logic pop;
   logic [CW-1:0] count_next;

   // Handshakes and next fill level.
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_valid = count != '0;
   assign out_data = mem[rd_ptr];
   always_comb begin
      count_next = count;
      if (flush) begin
         count_next = '0;
      end else if (push && !pop) begin
         count_next = count + CW'(1);
      end else if (pop && !push) begin
         count_next = count - CW'(1);
      end
   end

   // Pointers, level and registered ready.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         in_ready <= 1'b1;
      end else begin
         count <= count_next;
         in_ready <= count_next != CW'(DEPTH);
         if (flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
         end else begin
            if (push) begin
               wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop) begin
               rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
         end
      end
   end

   // Storage, written by index.
   always_ff @(posedge clock) begin
      if (push && !flush) begin
         mem[wr_ptr] <= in_data;
      end
   end
endmodule

// ****************************************
// Register block top
// ****************************************
module uic_regs #(
   parameter int DEPTH = 16
) (
   input wire logic clock, // 25 MHz system clock.
   input wire logic reset_n, // Asynchronous reset, active low.
   input wire logic [2:0] bus_addr, // Register address.
   input wire logic bus_wr, // Write strobe, one cycle.
   input wire logic bus_rd, // Read strobe, one cycle.
   input wire logic [7:0] bus_wdata, // Write data.
   output logic [7:0] bus_rdata, // Read data, valid after strobe.
   input wire logic rx_valid, // Receiver offers a character.
   input wire uic_pkg::uic_char_t rx_char, // Character and its errors.
   output logic rx_ready, // Buffer can take a character.
   input wire logic tx_hold_empty, // Transmit holding or FIFO empty.
   input wire logic tx_shift_empty, // Transmit shift register empty.
   input wire logic tx_trigger_hit, // Transmit spaces above trigger.
   input wire logic modem_change, // Modem status delta pending.
   input wire logic stop_char_seen, // Stop character detected.
   input wire logic rts_rise, // Request output rose.
   input wire logic cts_rise, // Clear-to-send input rose.
   output logic tx_load, // Transmit byte written, one cycle.
   output logic [7:0] tx_byte, // Transmit byte.
   output logic irq, // Interrupt request, active high.
   output uic_pkg::uic_cfg_t cfg // Configuration to other logic.
);
   localparam int CW = $clog2(DEPTH + 1);
   logic [7:0] div_low_reg, div_high_reg, fraction_reg, enhanced_reg;
   logic [7:0] resume1_reg, resume2_reg, pause1_reg, pause2_reg;
   logic [7:0] line_ctl_reg, interrupt_mask_reg;
   logic fifo_en_reg, overrun_reg, tx_pend_reg, tx_src_d;
   logic [1:0] rx_trig_reg, tx_trig_reg;
   logic [CW-1:0] count, err_cnt;
   logic [4:0] trig_lvl;
   int trig_eff;
   logic normal_map, div_map, enh_map, enh_on;
   logic wr_mask, wr_data, wr_fifo_ctl, rd_data, rd_source, rd_status;
   logic head_valid, pop, push, flush, rx_hit, tx_src;
   logic ls_pend, rx_pend, tx_on, ms_pend, stop_pend, flow_pend;
   logic [7:0] line_status, source_val, rdata_next;
   logic [5:0] src;
   uic_pkg::uic_char_t head;

   // Address map selection by line control value.
   assign enh_map = line_ctl_reg == uic_pkg::LINE_CTL_ENHANCED;
   assign div_map = line_ctl_reg[uic_pkg::LINE_CTL_DIV_BIT] && !enh_map;
   assign normal_map = !line_ctl_reg[uic_pkg::LINE_CTL_DIV_BIT];
   assign enh_on = enhanced_reg[uic_pkg::ENH_ENABLE_BIT];
   assign wr_data = bus_wr && normal_map && bus_addr == uic_pkg::A_DATA;
   assign wr_mask = bus_wr && normal_map && bus_addr == uic_pkg::A_MASK;
   assign wr_fifo_ctl = bus_wr && normal_map && bus_addr == uic_pkg::A_CTRL;
   assign rd_data = bus_rd && normal_map && bus_addr == uic_pkg::A_DATA;
   assign rd_source = bus_rd && normal_map && bus_addr == uic_pkg::A_CTRL;
   assign rd_status = bus_rd && normal_map && bus_addr == uic_pkg::A_LINE_STAT;
   assign flush = wr_fifo_ctl && bus_wdata[uic_pkg::FIFO_CTL_EN_BIT]
      && bus_wdata[uic_pkg::FIFO_CTL_RXRST_BIT];
   assign pop = rd_data && head_valid;
   assign push = rx_valid && rx_ready;

   // Receive buffer holding characters with their error flags.
   uic_fifo #(.WIDTH($bits(uic_pkg::uic_char_t)), .DEPTH(DEPTH)) rx_buf (
      .clock(clock),
      .reset_n(reset_n),
      .flush(flush),
      .in_valid(rx_valid),
      .in_data(rx_char),
      .in_ready(rx_ready),
      .out_valid(head_valid),
      .out_data(head),
      .out_ready(pop),
      .count(count)
   );

   // Divisor and fraction registers.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         div_low_reg <= uic_pkg::RST_BYTE;
         div_high_reg <= uic_pkg::RST_BYTE;
         fraction_reg <= uic_pkg::RST_BYTE;
      end else if (bus_wr && div_map) begin
         if (bus_addr == uic_pkg::A_DATA) begin
            div_low_reg <= bus_wdata;
         end
         if (bus_addr == uic_pkg::A_MASK) begin
            div_high_reg <= bus_wdata;
         end
         if (bus_addr == uic_pkg::A_CTRL && enh_on) begin
            fraction_reg <= bus_wdata;
         end
      end
   end

   // Enhanced register and flow characters, reachable only at BF.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enhanced_reg <= uic_pkg::RST_BYTE;
         resume1_reg <= uic_pkg::RST_BYTE;
         resume2_reg <= uic_pkg::RST_BYTE;
         pause1_reg <= uic_pkg::RST_BYTE;
         pause2_reg <= uic_pkg::RST_BYTE;
      end else if (bus_wr && enh_map) begin
         unique case (bus_addr)
            uic_pkg::A_CTRL: enhanced_reg <= bus_wdata;
            uic_pkg::A_RES1: resume1_reg <= bus_wdata;
            uic_pkg::A_RES2: resume2_reg <= bus_wdata;
            uic_pkg::A_PAU1: pause1_reg <= bus_wdata;
            uic_pkg::A_PAU2: pause2_reg <= bus_wdata;
            default: ;
         endcase
      end
   end

   // Line control register.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         line_ctl_reg <= uic_pkg::RST_BYTE;
      end else if (bus_wr && bus_addr == uic_pkg::A_LINE_CTL) begin
         line_ctl_reg <= bus_wdata;
      end
   end

   // Interrupt mask; upper nibble locked unless enhanced mode is on.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         interrupt_mask_reg <= uic_pkg::RST_BYTE;
      end else if (wr_mask) begin
         interrupt_mask_reg[3:0] <= bus_wdata[3:0];
         if (enh_on) begin
            interrupt_mask_reg[7:4] <= bus_wdata[7:4];
         end
      end
   end

   // FIFO control: enable and trigger selections.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         fifo_en_reg <= 1'b0;
         rx_trig_reg <= uic_pkg::RST_TRIG;
         tx_trig_reg <= uic_pkg::RST_TRIG;
      end else if (wr_fifo_ctl) begin
         fifo_en_reg <= bus_wdata[uic_pkg::FIFO_CTL_EN_BIT];
         if (bus_wdata[uic_pkg::FIFO_CTL_EN_BIT]) begin
            rx_trig_reg <= bus_wdata[7:6];
            if (enh_on) begin
               tx_trig_reg <= bus_wdata[5:4];
            end
         end
      end
   end

   // Count of stored characters carrying any error.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         err_cnt <= '0;
      end else if (flush) begin
         err_cnt <= '0;
      end else begin
         err_cnt <= err_cnt
            + CW'(push && (rx_char.brk || rx_char.frame || rx_char.parity))
            - CW'(pop && (head.brk || head.frame || head.parity));
      end
   end

   // Overrun: a character offered while full; read of status clears.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         overrun_reg <= 1'b0;
      end else if (rx_valid && !rx_ready) begin
         overrun_reg <= 1'b1;
      end else if (rd_status) begin
         overrun_reg <= 1'b0;
      end
   end

   // Line status view, polled by the host in either mode.
   assign line_status = {
      err_cnt != '0,
      tx_hold_empty && tx_shift_empty,
      tx_hold_empty,
      head_valid && head.brk,
      head_valid && head.frame,
      head_valid && head.parity,
      overrun_reg,
      head_valid
   };

   // Receive trigger level selection; a level beyond the depth clips to a full buffer.
   always_comb begin
      unique case (rx_trig_reg)
         2'h0: trig_lvl = uic_pkg::RX_TRIG_0;
         2'h1: trig_lvl = uic_pkg::RX_TRIG_1;
         2'h2: trig_lvl = uic_pkg::RX_TRIG_2;
         default: trig_lvl = uic_pkg::RX_TRIG_3;
      endcase
   end
   assign trig_eff = (int'(trig_lvl) > DEPTH) ? DEPTH : int'(trig_lvl);
   assign rx_hit = fifo_en_reg ? int'(count) >= trig_eff : head_valid;

   // Transmit-ready source: trigger in FIFO mode, holding empty otherwise.
   assign tx_src = fifo_en_reg ? tx_trigger_hit : tx_hold_empty;
   assign tx_on = wr_mask && bus_wdata[uic_pkg::M_TX]
      && !interrupt_mask_reg[uic_pkg::M_TX] && tx_hold_empty;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         tx_src_d <= 1'b1; // Starts high so an idle empty source is no false edge.
         tx_pend_reg <= 1'b0;
      end else begin
         tx_src_d <= tx_src;
         if ((tx_src && !tx_src_d) || tx_on) begin
            tx_pend_reg <= 1'b1;
         end else if (wr_data || (rd_source && src == uic_pkg::SRC_TX)) begin
            tx_pend_reg <= 1'b0;
         end
      end
   end

   // Masked pending sources.
   assign ls_pend = interrupt_mask_reg[uic_pkg::M_LS]
      && (line_status[1] || line_status[2] || line_status[3]
      || line_status[4] || line_status[7]);
   assign rx_pend = interrupt_mask_reg[uic_pkg::M_RX] && rx_hit;
   assign ms_pend = interrupt_mask_reg[uic_pkg::M_MS] && modem_change;
   assign stop_pend = enh_on && interrupt_mask_reg[uic_pkg::M_STOP]
      && stop_char_seen;
   assign flow_pend = enh_on
      && ((interrupt_mask_reg[uic_pkg::M_RTS] && rts_rise)
      || (interrupt_mask_reg[uic_pkg::M_CTS] && cts_rise));

   // Highest pending source by priority.
   always_comb begin
      if (ls_pend) begin
         src = uic_pkg::SRC_LS;
      end else if (rx_pend) begin
         src = uic_pkg::SRC_RX;
      end else if (tx_pend_reg && interrupt_mask_reg[uic_pkg::M_TX]) begin
         src = uic_pkg::SRC_TX;
      end else if (ms_pend) begin
         src = uic_pkg::SRC_MS;
      end else if (stop_pend) begin
         src = uic_pkg::SRC_STOP;
      end else if (flow_pend) begin
         src = uic_pkg::SRC_FLOW;
      end else begin
         src = uic_pkg::SRC_NONE;
      end
   end
   assign source_val = {fifo_en_reg, fifo_en_reg, src};

   // Read data multiplexer.
   always_comb begin
      rdata_next = uic_pkg::RST_BYTE;
      unique case (bus_addr)
         uic_pkg::A_DATA: rdata_next = div_map ? div_low_reg
            : (normal_map ? head.data : uic_pkg::RST_BYTE);
         uic_pkg::A_MASK: rdata_next = div_map ? div_high_reg
            : (normal_map ? interrupt_mask_reg : uic_pkg::RST_BYTE);
         uic_pkg::A_CTRL: rdata_next = enh_map ? enhanced_reg
            : (div_map ? (enh_on ? fraction_reg : uic_pkg::RST_BYTE) : source_val);
         uic_pkg::A_LINE_CTL: rdata_next = line_ctl_reg;
         uic_pkg::A_RES1: rdata_next = enh_map ? resume1_reg : uic_pkg::RST_BYTE;
         uic_pkg::A_RES2: rdata_next = enh_map ? resume2_reg : line_status;
         uic_pkg::A_PAU1: rdata_next = enh_map ? pause1_reg : uic_pkg::RST_BYTE;
         default: rdata_next = enh_map ? pause2_reg : uic_pkg::RST_BYTE;
      endcase
   end

   // Registered read data, transmit strobe and interrupt line.
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= uic_pkg::RST_BYTE;
         tx_load <= 1'b0;
         tx_byte <= uic_pkg::RST_BYTE;
         irq <= 1'b0;
      end else begin
         if (bus_rd) begin
            bus_rdata <= rdata_next;
         end
         tx_load <= wr_data;
         if (wr_data) begin
            tx_byte <= bus_wdata;
         end
         irq <= src != uic_pkg::SRC_NONE;
      end
   end

   // Configuration bundle, each field straight from its register.
   assign cfg = '{div_low: div_low_reg, div_high: div_high_reg,
      fraction: fraction_reg, enhanced: enhanced_reg,
      resume1: resume1_reg, resume2: resume2_reg,
      pause1: pause1_reg, pause2: pause2_reg,
      line_ctl: line_ctl_reg, mask: interrupt_mask_reg,
      fifo_en: fifo_en_reg, tx_trig: tx_trig_reg};

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);

   sequence s_tx_arm;
      tx_on && !wr_data;
   endsequence
   sequence s_err_push;
      push && !flush && (rx_char.brk || rx_char.frame || rx_char.parity);
   endsequence

   mask_gate_a: assert property (
      interrupt_mask_reg == 8'h00 |=> !irq)
      else $error("Interrupt with all sources masked.");
   rx_trig_a: assert property (
      fifo_en_reg && interrupt_mask_reg[0] && int'(count) >= trig_eff |=> irq)
      else $error("Receive trigger did not interrupt.");
   rx_code_a: assert property (
      rx_pend && !ls_pend |-> source_val[3:0] == 4'h4)
      else $error("Receive source code missing.");
   data_ready_a: assert property (
      push && !flush |=> line_status[0])
      else $error("Data ready not set after push.");
   overrun_a: assert property (
      rx_valid && !rx_ready && interrupt_mask_reg[2] |=> overrun_reg ##1 irq)
      else $error("Overrun not flagged at once.");
   head_err_a: assert property (
      line_status[4:2] != 3'h0 |-> line_status[7] && line_status[0])
      else $error("Head error without stored error.");
   tx_empty_a: assert property (
      rd_status |=> bus_rdata[6:5] == $past({tx_hold_empty && tx_shift_empty, tx_hold_empty}))
      else $error("Line status empty bits read back wrong.");
   err_any_a: assert property (
      s_err_push |=> line_status[7])
      else $error("Errored character not counted.");
   tx_arm_a: assert property (
      s_tx_arm |=> tx_pend_reg ##1 (irq || !interrupt_mask_reg[1]))
      else $error("Enabling with holding empty gave no interrupt.");
   ls_hold_a: assert property (
      interrupt_mask_reg[2] && line_status[7] && !bus_wr |=> irq)
      else $error("Line status interrupt dropped.");
   sleep_lock_a: assert property (
      wr_mask && !enh_on |=> $stable(interrupt_mask_reg[7:4]))
      else $error("Enhanced mask bits written while locked.");
   enh_map_a: assert property (
      bus_wr && bus_addr == 3'h4 && !enh_map |=> $stable(resume1_reg))
      else $error("Flow character written outside BF map.");
endmodule

/* File: verification/uic_host.sv */
// Host processor model that drives the parallel register bus.
`timescale 1ns/1ps

// ****************************************
// Host bus model
// ****************************************
module uic_host (
   input wire logic clock, // System clock.
   output logic [2:0] bus_addr, // Register address.
   output logic bus_wr, // Write strobe.
   output logic bus_rd, // Read strobe.
   output logic [7:0] bus_wdata, // Write data.
   input wire logic [7:0] bus_rdata, // Read data.
   output logic rvalid, // Read result present for one cycle.
   output logic [7:0] rvalue // Read result.
);
   // The bus idles with both strobes low.
   initial begin
      bus_addr = 3'h0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_wdata = 8'h00;
      rvalid = 1'b0;
      rvalue = 8'h00;
   end

   // One-cycle write; the caller selects the map through line control first.
   task automatic write(input logic [2:0] a, input logic [7:0] d);
      @(posedge clock);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clock);
      bus_wr <= 1'b0;
      bus_wdata <= ~d;
   endtask

   // One-cycle read; data is taken once it has settled after the strobe.
   task automatic read(input logic [2:0] a);
      @(posedge clock);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clock);
      bus_rd <= 1'b0;
      @(posedge clock);
      rvalue <= bus_rdata;
      rvalid <= 1'b1;
      @(posedge clock);
      rvalid <= 1'b0;
   endtask
endmodule

/* File: verification/uic_regs_tb.sv */
// Self-checking testbench for the channel register block.
`timescale 1ns/1ps
module uic_regs_tb;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic rx_valid = 1'b0;
   uic_pkg::uic_char_t rx_char = '0;
   logic tx_hold_empty = 1'b1;
   logic tx_shift_empty = 1'b1;
   logic tx_trigger_hit = 1'b0;
   logic modem_change = 1'b0;
   logic stop_char_seen = 1'b0;
   logic rts_rise = 1'b0;
   logic cts_rise = 1'b0;
   logic [2:0] bus_addr;
   logic bus_wr, bus_rd, rvalid, rx_ready, tx_load, irq;
   logic [7:0] bus_wdata, bus_rdata, rvalue, tx_byte, r;
   logic [7:0] dq[4];
   uic_pkg::uic_cfg_t cfg;
   logic [7:0] expq[$];
   logic [31:0] lfsr = 32'h6754;
   int miscompares = 0;
   int check_count = 0;
   int cycles = 0;

   // Clock at 25 MHz.
   always #20 clock = ~clock;

   uic_regs #(.DEPTH(4)) u_uic_regs (.clock(clock), .reset_n(reset_n), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .rx_valid(rx_valid), .rx_char(rx_char), .rx_ready(rx_ready),
      .tx_hold_empty(tx_hold_empty), .tx_shift_empty(tx_shift_empty),
      .tx_trigger_hit(tx_trigger_hit), .modem_change(modem_change),
      .stop_char_seen(stop_char_seen), .rts_rise(rts_rise), .cts_rise(cts_rise),
      .tx_load(tx_load), .tx_byte(tx_byte), .irq(irq), .cfg(cfg));

   uic_host u_uic_host (.clock(clock), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .rvalid(rvalid), .rvalue(rvalue));

   function automatic logic [7:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr[7:0];
   endfunction

   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic final_report();
      $display("Checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      expq.push_back(e);
      u_uic_host.read(a);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      u_uic_host.write(a, d);
   endtask

   // Offer one character; a stale value never stays on the lines.
   task automatic push(input logic [7:0] d, input logic par);
      @(posedge clock);
      rx_valid <= 1'b1;
      rx_char <= {d, 2'b00, par};
      @(posedge clock);
      rx_valid <= 1'b0;
      rx_char <= ~{d, 2'b00, par};
   endtask

   task automatic irq_is(input logic e);
      repeat (3) @(posedge clock);
      chk("irq", {7'h00, e}, {7'h00, irq});
   endtask

   // Each read result is compared with the oldest expectation.
   always @(posedge clock) begin
      if (rvalid === 1'b1) begin
         chk("read", expq.pop_front(), rvalue);
      end
   end

   // Cuts a hang short.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         miscompares++;
         final_report();
      end
   end

   // Main sequence.
   initial begin
      repeat (10) @(posedge clock);
      reset_n <= 1'b1;
      rd(uic_pkg::A_MASK, 8'h00);
      rd(uic_pkg::A_LINE_STAT, 8'h60);
      tx_shift_empty <= 1'b0;
      rd(uic_pkg::A_LINE_STAT, 8'h20);
      tx_shift_empty <= 1'b1;
      wr(uic_pkg::A_MASK, 8'hff);
      rd(uic_pkg::A_MASK, 8'h0f);
      wr(uic_pkg::A_LINE_CTL, 8'h80);
      for (int i = 0; i < 2; i++) begin
         r = rnd();
         wr(3'(i), r);
         rd(3'(i), r);
      end
      wr(uic_pkg::A_CTRL, rnd());
      rd(uic_pkg::A_CTRL, 8'h00);
      wr(uic_pkg::A_LINE_CTL, 8'hbf);
      rd(uic_pkg::A_DATA, 8'h00);
      wr(uic_pkg::A_CTRL, 8'h10);
      @(posedge clock);
      chk("enhanced", 8'h10, cfg.enhanced);
      for (int i = 4; i < 8; i++) begin
         r = rnd();
         wr(3'(i), r);
         rd(3'(i), r);
      end
      wr(uic_pkg::A_LINE_CTL, 8'h80);
      r = rnd();
      wr(uic_pkg::A_CTRL, r);
      rd(uic_pkg::A_CTRL, r);
      chk("fraction", r, cfg.fraction);
      wr(uic_pkg::A_LINE_CTL, 8'h00);
      wr(uic_pkg::A_MASK, 8'hf0);
      rd(uic_pkg::A_MASK, 8'hf0);
      wr(uic_pkg::A_MASK, 8'h00);
      irq_is(1'b0);
      wr(uic_pkg::A_MASK, 8'h02);
      irq_is(1'b1);
      rd(uic_pkg::A_CTRL, 8'h02);
      irq_is(1'b0);
      modem_change <= 1'b1;
      wr(uic_pkg::A_MASK, 8'h08);
      irq_is(1'b1);
      rd(uic_pkg::A_CTRL, 8'h00);
      wr(uic_pkg::A_MASK, 8'h00);
      irq_is(1'b0);
      modem_change <= 1'b0;
      stop_char_seen <= 1'b1;
      wr(uic_pkg::A_MASK, 8'h20);
      irq_is(1'b1);
      rd(uic_pkg::A_CTRL, 8'h10);
      stop_char_seen <= 1'b0;
      cts_rise <= 1'b1;
      wr(uic_pkg::A_MASK, 8'h80);
      rd(uic_pkg::A_CTRL, 8'h20);
      cts_rise <= 1'b0;
      wr(uic_pkg::A_MASK, 8'h01);
      push(8'h3c, 1'b0);
      irq_is(1'b1);
      rd(uic_pkg::A_CTRL, 8'h04);
      rd(uic_pkg::A_DATA, 8'h3c);
      irq_is(1'b0);
      wr(uic_pkg::A_CTRL, 8'h43);
      wr(uic_pkg::A_MASK, 8'h01);
      for (int i = 0; i < 4; i++) begin
         dq[i] = rnd();
         push(dq[i], 1'b0);
         if (i == 2) irq_is(1'b0);
         if (i == 0) rd(uic_pkg::A_LINE_STAT, 8'h61);
      end
      irq_is(1'b1);
      chk("rx_ready", 8'h00, {7'h00, rx_ready});
      rd(uic_pkg::A_CTRL, 8'hc4);
      rd(uic_pkg::A_DATA, dq[0]);
      irq_is(1'b0);
      push(8'h5a, 1'b1);
      wr(uic_pkg::A_MASK, 8'h04);
      push(8'ha5, 1'b0);
      irq_is(1'b1);
      rd(uic_pkg::A_LINE_STAT, 8'he3);
      for (int i = 1; i < 4; i++) rd(uic_pkg::A_DATA, dq[i]);
      rd(uic_pkg::A_LINE_STAT, 8'he5);
      irq_is(1'b1);
      rd(uic_pkg::A_DATA, 8'h5a);
      rd(uic_pkg::A_LINE_STAT, 8'h60);
      irq_is(1'b0);
      tx_hold_empty <= 1'b0;
      wr(uic_pkg::A_MASK, 8'h02);
      irq_is(1'b0);
      tx_trigger_hit <= 1'b1;
      irq_is(1'b1);
      r = rnd();
      wr(uic_pkg::A_DATA, r);
      @(posedge clock);
      chk("tx_load", 8'h01, {7'h00, tx_load});
      chk("tx_byte", r, tx_byte);
      irq_is(1'b0);
      final_report();
   end
endmodule
